// >>> session_context_defines.vh
// Context layout, control word fields and encodings for the session context decoder.
`ifndef SESSION_CONTEXT_DEFINES_VH
`define SESSION_CONTEXT_DEFINES_VH

`define CTX_CTRL_WORD       6'd0
`define CTX_MAC_KEY_BASE    6'd1
`define CTX_CIPHER_KEY_BASE 6'd9
`define CTX_MAC_IV_BASE     6'd17
`define CTX_CIPHER_IV_BASE  6'd25
`define CTX_WORDS           6'd29

`define CW_VERIFY           29
`define CW_MAC_ONLY         27
`define CW_OR_ENABLE        26
`define CW_TRUNCATED        25
`define CW_KEEP_HASH        24
`define CW_RELOAD_KEYS      23
`define CW_TAKE_VECTOR      22
`define CW_FIRST_BLOCK      21
`define CW_OUTGOING         20
`define CW_PRIM_HI          16
`define CW_PRIM_LO          10
`define CW_DIRECTION        9
`define CW_KEYLEN_HI        8
`define CW_KEYLEN_LO        7
`define CW_COMBINE_HI       6
`define CW_COMBINE_LO       4
`define CW_CHAIN_HI         3
`define CW_CHAIN_LO         0
`define CW_RESERVED_MASK    32'hD00E_0000

`define PRIM_HMAC           6
`define PRIM_SHA256         5
`define PRIM_SHA1           4
`define PRIM_MD5            3
`define PRIM_AES            2
`define PRIM_TDES           1
`define PRIM_DES            0

`define KEYLEN_128          2'h0
`define KEYLEN_192          2'h1
`define KEYLEN_256          2'h2
`define KEYLEN_RSVD         2'h3

`define COMBINE_SINGLE      3'h0
`define COMBINE_PIPE        3'h5
`define COMBINE_PARALLEL    3'h7

`define CHAIN_AES_CTR       4'hD
`define CHAIN_AES_GCM       4'hE
`define CHAIN_RSVD          4'hF
`define CHAIN_AES_FIRST     4'h8

`define TRUNC_RESULT_WORDS  4'h3
`define RESULT_WORDS_MAX    4'h8

`endif

// >>> session_context_decoder.v
// Session context fetcher, control word decoder and result poster.
`timescale 1ns/1ps
`include "session_context_defines.vh"
// What this block does
// - Take all settings from the security context.
// - Fetch only context words the flow needs.
// - Bit 27 computes check value, suppresses output.
// - Bit 26 ORs control bits into status.
// - Bit 25 truncates SHA-1 HMAC to three words.
// - Bit 24 saves intermediate hash result.
// - Bit 23 reloads cipher and MAC keys.
// - Bit 22 loads vector, else chained vector.
// - Bit 21 marks the first block.
// - Bit 20 gives flow direction, one outgoing.
// - Bits 16-10 pick primitives, one bit each.
// - Bit 9 one encrypts, zero decrypts.
// - Bits 8-7 select 128, 192, 256 key.
// - Key length only changes bits used.
// - Bits 6-4 select combined operation mode.
// - Bits 3-0 select cipher chaining mode.
// - Counter mode uses a 32-bit counter only.
// - Vector words are big-endian, high word first.
// - Hash results written big-endian at pointer.
// - Fetch context only when descriptor requests it.
// - Post results at the result pointer.
module session_context_decoder #(
  parameter AW = 32
) (
  input  wire          i_clock,
  input  wire          i_rst_b,
  input  wire          i_packet_start,
  input  wire          i_session_fetch_request,
  input  wire [AW-1:0] i_context_pointer,
  input  wire [AW-1:0] i_result_post_pointer,
  input  wire [31:0]   i_status_value,
  output reg           o_mem_rd_req,
  output reg  [AW-1:0] o_mem_rd_addr,
  input  wire          i_mem_rd_valid,
  input  wire [31:0]   i_mem_rd_data,
  input  wire          i_result_valid,
  input  wire [255:0]  i_result_data,
  input  wire [3:0]    i_result_words,
  output wire          o_result_ready,
  output reg           o_mem_wr_req,
  output reg  [AW-1:0] o_mem_wr_addr,
  output reg  [31:0]   o_mem_wr_data,
  input  wire          i_mem_wr_ack,
  output reg           o_context_ready,
  output wire          o_busy,
  output reg  [31:0]   o_session_control_word,
  output reg  [255:0]  o_mac_key_words,
  output reg  [255:0]  o_cipher_key_words,
  output reg  [255:0]  o_mac_init_vector_words,
  output reg  [127:0]  o_cipher_init_vector_words,
  output reg  [255:0]  o_cipher_key_used,
  output reg  [31:0]   o_status_merged,
  output wire [6:0]    o_primitive_select,
  output wire          o_cipher_direction,
  output wire [1:0]    o_key_length_select,
  output wire [2:0]    o_combined_operation_mode,
  output wire [3:0]    o_cipher_chaining_mode,
  output wire          o_mac_only,
  output wire          o_truncated_mac_result,
  output wire          o_keep_intermediate_hash,
  output wire          o_reload_keys,
  output wire          o_take_vector_from_session,
  output wire          o_first_block_marker,
  output wire          o_outgoing_flow,
  output wire          o_counter_32bit,
  output wire          o_config_error,
  output reg           o_result_done
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_CTRL  = 3'd1;
  localparam ST_BODY  = 3'd2;
  localparam ST_READY = 3'd3;
  localparam ST_POST  = 3'd4;

  reg [2:0]    state_q;
  reg [5:0]    word_q;
  reg [AW-1:0] base_q;
  reg [AW-1:0] post_q;
  reg [255:0]  result_q;
  reg [3:0]    post_left_q;
  reg [31:0]   ctrl_q;
  reg [5:0]    next_word;
  reg [255:0]  key_mask;
  reg          need_keys;
  reg          need_civ;
  reg          need_miv;
  wire [5:0]   rd_word;

  // Current control word: the freshly fetched one while the body is fetched.
  always @* ctrl_q = o_session_control_word;

  assign o_primitive_select         = ctrl_q[`CW_PRIM_HI:`CW_PRIM_LO];
  assign o_cipher_direction         = ctrl_q[`CW_DIRECTION];
  assign o_key_length_select        = ctrl_q[`CW_KEYLEN_HI:`CW_KEYLEN_LO];
  assign o_combined_operation_mode  = ctrl_q[`CW_COMBINE_HI:`CW_COMBINE_LO];
  assign o_cipher_chaining_mode     = ctrl_q[`CW_CHAIN_HI:`CW_CHAIN_LO];
  assign o_mac_only                 = ctrl_q[`CW_MAC_ONLY];
  assign o_keep_intermediate_hash   = ctrl_q[`CW_KEEP_HASH];
  assign o_reload_keys              = ctrl_q[`CW_RELOAD_KEYS];
  assign o_take_vector_from_session = ctrl_q[`CW_TAKE_VECTOR];
  assign o_first_block_marker       = ctrl_q[`CW_FIRST_BLOCK];
  assign o_outgoing_flow            = ctrl_q[`CW_OUTGOING];
  // Truncation applies to keyed SHA-1 only; flows without both HMAC and SHA-1 selected ignore the bit.
  assign o_truncated_mac_result = ctrl_q[`CW_TRUNCATED] & ctrl_q[`CW_PRIM_LO + `PRIM_HMAC]
                                  & ctrl_q[`CW_PRIM_LO + `PRIM_SHA1];
  assign o_counter_32bit = ctrl_q[`CW_PRIM_LO + `PRIM_AES]
                           & (o_cipher_chaining_mode == `CHAIN_AES_CTR);
  // Flags software mistakes; the engine does not police them further.
  assign o_config_error = ((ctrl_q & `CW_RESERVED_MASK) != 32'h0000_0000)
                          | ctrl_q[`CW_VERIFY]
                          | (o_key_length_select == `KEYLEN_RSVD)
                          | (o_cipher_chaining_mode == `CHAIN_RSVD)
                          | ((o_combined_operation_mode != `COMBINE_SINGLE)
                             & (o_combined_operation_mode != `COMBINE_PIPE)
                             & (o_combined_operation_mode != `COMBINE_PARALLEL));

  assign o_busy         = (state_q != ST_IDLE) & (state_q != ST_READY);
  assign o_result_ready = (state_q == ST_READY);

  // Which context areas this flow needs.
  always @* begin
    need_keys = ctrl_q[`CW_RELOAD_KEYS];
    need_civ  = ctrl_q[`CW_TAKE_VECTOR]
                & (|ctrl_q[`CW_PRIM_LO + `PRIM_AES:`CW_PRIM_LO + `PRIM_DES]);
    need_miv  = ctrl_q[`CW_TAKE_VECTOR]
                & (|ctrl_q[`CW_PRIM_HI:`CW_PRIM_LO + `PRIM_MD5]);
  end

  // Next needed word after word_q, or the end marker.
  always @* begin
    next_word = word_q + 6'd1;
    if (next_word < `CTX_CIPHER_KEY_BASE && !(need_keys && (|ctrl_q[`CW_PRIM_HI:`CW_PRIM_LO
        + `PRIM_MD5])))
      next_word = `CTX_CIPHER_KEY_BASE;
    if (next_word >= `CTX_CIPHER_KEY_BASE && next_word < `CTX_MAC_IV_BASE
        && !(need_keys && (|ctrl_q[`CW_PRIM_LO + `PRIM_AES:`CW_PRIM_LO + `PRIM_DES])))
      next_word = `CTX_MAC_IV_BASE;
    if (next_word >= `CTX_MAC_IV_BASE && next_word < `CTX_CIPHER_IV_BASE && !need_miv)
      next_word = `CTX_CIPHER_IV_BASE;
    if (next_word >= `CTX_CIPHER_IV_BASE && next_word < `CTX_WORDS && !need_civ)
      next_word = `CTX_WORDS;
  end

  // Key length only narrows the bits used; storage keeps full width.
  always @* begin
    case (o_key_length_select)
      `KEYLEN_192: key_mask = {{192{1'b1}}, 64'h0000_0000_0000_0000};
      `KEYLEN_256: key_mask = {256{1'b1}};
      default:     key_mask = {{128{1'b1}}, 128'h0};
    endcase
    o_cipher_key_used = o_cipher_key_words & key_mask;
  end

  assign rd_word = word_q;

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q                    <= ST_IDLE;
      word_q                     <= 6'd0;
      base_q                     <= {AW{1'b0}};
      post_q                     <= {AW{1'b0}};
      result_q                   <= 256'h0;
      post_left_q                <= 4'h0;
      o_mem_rd_req               <= 1'b0;
      o_mem_rd_addr              <= {AW{1'b0}};
      o_mem_wr_req               <= 1'b0;
      o_mem_wr_addr              <= {AW{1'b0}};
      o_mem_wr_data              <= 32'h0000_0000;
      o_context_ready            <= 1'b0;
      o_session_control_word     <= 32'h0000_0000;
      o_mac_key_words            <= 256'h0;
      o_cipher_key_words         <= 256'h0;
      o_mac_init_vector_words    <= 256'h0;
      o_cipher_init_vector_words <= 128'h0;
      o_status_merged            <= 32'h0000_0000;
      o_result_done              <= 1'b0;
    end else begin
      o_result_done <= 1'b0;
      // Status view follows the OR option continuously.
      o_status_merged <= ctrl_q[`CW_OR_ENABLE] ? (i_status_value | ctrl_q)
                                               : i_status_value;
      case (state_q)
        ST_IDLE, ST_READY: begin
          if (i_packet_start) begin
            if (i_session_fetch_request) begin
              base_q          <= i_context_pointer;
              word_q          <= `CTX_CTRL_WORD;
              o_mem_rd_addr   <= i_context_pointer;
              o_mem_rd_req    <= 1'b1;
              o_context_ready <= 1'b0;
              state_q         <= ST_CTRL;
            end else begin
              o_context_ready <= 1'b1;
              state_q         <= ST_READY;
            end
            post_q <= i_result_post_pointer;
          end else if (state_q == ST_READY && i_result_valid) begin
            result_q    <= i_result_data;
            post_left_q <= o_truncated_mac_result ? `TRUNC_RESULT_WORDS
                         : ((i_result_words > `RESULT_WORDS_MAX) ? `RESULT_WORDS_MAX
                                                                 : i_result_words);
            o_mem_wr_req  <= 1'b1;
            o_mem_wr_addr <= post_q;
            o_mem_wr_data <= i_result_data[255:224];
            state_q       <= ST_POST;
          end
        end
        ST_CTRL: begin
          if (i_mem_rd_valid) begin
            o_session_control_word <= i_mem_rd_data;
            state_q                <= ST_BODY;
            o_mem_rd_req           <= 1'b0;
          end
        end
        ST_BODY: begin
          // Skip decision uses the control word stored last cycle.
          if (!o_mem_rd_req || i_mem_rd_valid) begin
            if (o_mem_rd_req) begin
              if (rd_word < `CTX_CIPHER_KEY_BASE)
                o_mac_key_words[(8 - (rd_word - `CTX_MAC_KEY_BASE)) * 32 - 1 -: 32]
                  <= i_mem_rd_data;
              else if (rd_word < `CTX_MAC_IV_BASE)
                o_cipher_key_words[(8 - (rd_word - `CTX_CIPHER_KEY_BASE)) * 32 - 1 -: 32]
                  <= i_mem_rd_data;
              else if (rd_word < `CTX_CIPHER_IV_BASE)
                o_mac_init_vector_words[(8 - (rd_word - `CTX_MAC_IV_BASE)) * 32 - 1 -: 32]
                  <= i_mem_rd_data;
              else
                o_cipher_init_vector_words[(4 - (rd_word - `CTX_CIPHER_IV_BASE)) * 32 - 1 -: 32]
                  <= i_mem_rd_data;
            end
            if (next_word >= `CTX_WORDS) begin
              o_mem_rd_req    <= 1'b0;
              o_context_ready <= 1'b1;
              state_q         <= ST_READY;
            end else begin
              word_q        <= next_word;
              o_mem_rd_addr <= base_q + {{(AW-8){1'b0}}, next_word, 2'b00};
              o_mem_rd_req  <= 1'b1;
            end
          end
        end
        ST_POST: begin
          if (i_mem_wr_ack) begin
            if (post_left_q <= 4'h1) begin
              o_mem_wr_req  <= 1'b0;
              o_result_done <= 1'b1;
              state_q       <= ST_READY;
            end else begin
              post_left_q   <= post_left_q - 4'h1;
              result_q      <= {result_q[223:0], 32'h0000_0000};
              o_mem_wr_addr <= o_mem_wr_addr + {{(AW-3){1'b0}}, 3'b100};
              o_mem_wr_data <= result_q[223:192];
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // session_context_decoder

// >>> session_context_decoder_properties.sv
// Concurrent checks on the ports of the session context decoder.
`timescale 1ns/1ps
module session_context_decoder_properties (
  input wire         i_clock,
  input wire         i_rst_b,
  input wire         i_packet_start,
  input wire         i_session_fetch_request,
  input wire [31:0]  i_context_pointer,
  input wire         o_mem_rd_req,
  input wire [31:0]  o_mem_rd_addr,
  input wire         i_mem_rd_valid,
  input wire         o_mem_wr_req,
  input wire [31:0]  o_mem_wr_addr,
  input wire [31:0]  o_mem_wr_data,
  input wire         i_mem_wr_ack,
  input wire         o_context_ready,
  input wire         o_busy,
  input wire         o_result_done,
  input wire [31:0]  o_session_control_word,
  input wire [255:0] o_cipher_key_words,
  input wire [255:0] o_cipher_key_used,
  input wire         o_truncated_mac_result,
  input wire         o_counter_32bit
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  wire [31:0] w = o_session_control_word;
  property p_trunc; o_truncated_mac_result == (w[25] & w[16] & w[14]); endproperty
  a_trunc: assert property (p_trunc) else $error("truncation flag wrong");
  property p_ctr; o_counter_32bit == (w[12] && w[3:0] == 4'hD); endproperty
  a_ctr: assert property (p_ctr) else $error("counter mode flag wrong");
  property p_key_used;
    w[8:7] != 2'h3 |->
      o_cipher_key_used == (o_cipher_key_words & (~256'h0 << (128 - 64 * w[8:7])));
  endproperty
  a_key_used: assert property (p_key_used) else $error("key mask wrong");
  property p_fetch;
    i_packet_start && i_session_fetch_request && !o_busy |=>
      o_mem_rd_req && o_mem_rd_addr == $past(i_context_pointer);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not start");
  property p_keep;
    i_packet_start && !i_session_fetch_request && !o_busy |=> o_context_ready;
  endproperty
  a_keep: assert property (p_keep) else $error("kept context not ready");
  property p_rd_hold;
    o_mem_rd_req && !i_mem_rd_valid |=> o_mem_rd_req && $stable(o_mem_rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
  property p_wr_hold;
    o_mem_wr_req && !i_mem_wr_ack |=> o_mem_wr_req && $stable({o_mem_wr_addr, o_mem_wr_data});
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request dropped");
  property p_wr_step;
    o_mem_wr_req && i_mem_wr_ack ##1 o_mem_wr_req |->
      o_mem_wr_addr == $past(o_mem_wr_addr) + 32'h4;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("result address step wrong");
  property p_done;
    o_result_done |-> $past(o_mem_wr_req && i_mem_wr_ack) && !o_mem_wr_req;
  endproperty
  a_done: assert property (p_done) else $error("done without last write");
endmodule // session_context_decoder_properties
bind session_context_decoder session_context_decoder_properties u_properties (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_packet_start(i_packet_start),
  .i_session_fetch_request(i_session_fetch_request), .i_context_pointer(i_context_pointer),
  .o_mem_rd_req(o_mem_rd_req), .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_valid(i_mem_rd_valid),
  .o_mem_wr_req(o_mem_wr_req), .o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data),
  .i_mem_wr_ack(i_mem_wr_ack), .o_context_ready(o_context_ready), .o_busy(o_busy),
  .o_result_done(o_result_done), .o_session_control_word(o_session_control_word),
  .o_cipher_key_words(o_cipher_key_words), .o_cipher_key_used(o_cipher_key_used),
  .o_truncated_mac_result(o_truncated_mac_result), .o_counter_32bit(o_counter_32bit));

// >>> context_memory_model.sv
// Behavioural system memory answering context reads and result writes.
`timescale 1ns/1ps
module context_memory_model (
  input  wire        i_clock,
  input  wire [1:0]  i_delay,
  input  wire        i_rd_req,
  input  wire [31:0] i_rd_addr,
  output reg         o_rd_valid = 0,
  output reg  [31:0] o_rd_data = 0,
  input  wire        i_wr_req,
  input  wire [31:0] i_wr_addr,
  input  wire [31:0] i_wr_data,
  output reg         o_wr_ack = 0
);
  reg     [31:0] mem [0:255];
  int            rd_log[$];
  integer        rd_wait = 0, wr_wait = 0;
  always @(posedge i_clock) begin
    #1;
    if (o_rd_valid) o_rd_valid = 0;
    else if (i_rd_req && rd_wait++ >= i_delay) begin
      rd_wait = 0;
      rd_log.push_back(i_rd_addr[9:2]);
      o_rd_valid = 1;
      o_rd_data = mem[i_rd_addr[9:2]];
    end
    // Released data flips every cycle so a stale word never passes for a fresh one.
    if (!o_rd_valid) o_rd_data = ~o_rd_data;
    if (o_wr_ack) o_wr_ack = 0;
    else if (i_wr_req && wr_wait++ >= i_delay) begin
      wr_wait = 0;
      mem[i_wr_addr[9:2]] = i_wr_data;
      o_wr_ack = 1;
    end
  end
endmodule // context_memory_model

// >>> session_context_decoder_tb.sv
// Self-checking bench for the session context decoder against a queue-based model.
`timescale 1ns/1ps
module session_context_decoder_tb;
  reg          i_clock = 0, i_rst_b = 0, i_packet_start = 0, i_session_fetch_request = 0;
  reg          i_result_valid = 0;
  reg  [31:0]  i_context_pointer = 32'h0000_0040, i_result_post_pointer = 32'h0000_0200;
  reg  [31:0]  i_status_value = 0, ec = 0, c;
  reg  [255:0] i_result_data = 0, km;
  reg  [895:0] e_all = 0;
  reg  [3:0]   i_result_words = 0;
  reg  [1:0]   delay = 0;
  wire         o_mem_rd_req, i_mem_rd_valid, o_result_ready, o_mem_wr_req, i_mem_wr_ack, o_busy;
  wire         o_context_ready, o_cipher_direction, o_mac_only, o_truncated_mac_result;
  wire         o_keep_intermediate_hash, o_reload_keys, o_take_vector_from_session, o_result_done;
  wire         o_first_block_marker, o_outgoing_flow, o_counter_32bit, o_config_error;
  wire [31:0]  o_mem_rd_addr, i_mem_rd_data, o_mem_wr_addr, o_mem_wr_data, o_status_merged;
  wire [31:0]  o_session_control_word;
  wire [255:0] o_mac_key_words, o_cipher_key_words, o_mac_init_vector_words, o_cipher_key_used;
  wire [127:0] o_cipher_init_vector_words;
  wire [6:0]   o_primitive_select;
  wire [3:0]   o_cipher_chaining_mode;
  wire [2:0]   o_combined_operation_mode;
  wire [1:0]   o_key_length_select;
  wire [895:0] ctx_out = {o_mac_key_words, o_cipher_key_words, o_mac_init_vector_words,
                          o_cipher_init_vector_words};
  integer      failures = 0, comparisons = 0, seed = 32'hb61f_23ab, i, n, m, k;
  int          exp_rd[$];
  session_context_decoder DUT (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_packet_start(i_packet_start), .i_session_fetch_request(i_session_fetch_request),
    .i_context_pointer(i_context_pointer), .i_result_post_pointer(i_result_post_pointer),
    .i_status_value(i_status_value), .o_mem_rd_req(o_mem_rd_req),
    .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_valid(i_mem_rd_valid),
    .i_mem_rd_data(i_mem_rd_data), .i_result_valid(i_result_valid),
    .i_result_data(i_result_data), .i_result_words(i_result_words),
    .o_result_ready(o_result_ready), .o_mem_wr_req(o_mem_wr_req),
    .o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data), .i_mem_wr_ack(i_mem_wr_ack),
    .o_context_ready(o_context_ready), .o_busy(o_busy),
    .o_session_control_word(o_session_control_word), .o_mac_key_words(o_mac_key_words),
    .o_cipher_key_words(o_cipher_key_words), .o_mac_init_vector_words(o_mac_init_vector_words),
    .o_cipher_init_vector_words(o_cipher_init_vector_words),
    .o_cipher_key_used(o_cipher_key_used), .o_status_merged(o_status_merged),
    .o_primitive_select(o_primitive_select), .o_cipher_direction(o_cipher_direction),
    .o_key_length_select(o_key_length_select),
    .o_combined_operation_mode(o_combined_operation_mode),
    .o_cipher_chaining_mode(o_cipher_chaining_mode), .o_mac_only(o_mac_only),
    .o_truncated_mac_result(o_truncated_mac_result),
    .o_keep_intermediate_hash(o_keep_intermediate_hash), .o_reload_keys(o_reload_keys),
    .o_take_vector_from_session(o_take_vector_from_session),
    .o_first_block_marker(o_first_block_marker), .o_outgoing_flow(o_outgoing_flow),
    .o_counter_32bit(o_counter_32bit), .o_config_error(o_config_error),
    .o_result_done(o_result_done));
  context_memory_model far (.i_clock(i_clock), .i_delay(delay), .i_rd_req(o_mem_rd_req),
    .i_rd_addr(o_mem_rd_addr), .o_rd_valid(i_mem_rd_valid), .o_rd_data(i_mem_rd_data),
    .i_wr_req(o_mem_wr_req), .i_wr_addr(o_mem_wr_addr), .i_wr_data(o_mem_wr_data),
    .o_wr_ack(i_mem_wr_ack));
  initial forever #5 i_clock = ~i_clock;
  // Thirty packets need well under ten thousand cycles, so this span only trips on a hang.
  initial begin
    #200000 failures++;
    close_out;
  end
  task step;
    @(posedge i_clock);
    #1;
  endtask
  task chk(input [1023:0] got, input [1023:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task close_out;
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task run_case(input f);
    for (i = 0; i < 29; i++) far.mem[16 + i] = i ? $random(seed) : c;
    // Only three vector words carry meaning in GCM, so the fourth is left zero.
    if (c[3:0] == 4'hE) far.mem[44] = 32'h0000_0000;
    far.rd_log.delete();
    exp_rd.delete();
    if (f) begin
      ec = c;
      exp_rd.push_back(16);
      for (i = 1; i < 29; i++)
        if (c[i < 17 ? 23 : 22] && (((i - 1) / 8) % 2 ? |c[12:10] : |c[16:13])) begin
          exp_rd.push_back(16 + i);
          e_all[895 - 32 * (i - 1) -: 32] = far.mem[16 + i];
        end
    end
    delay = $random(seed);
    i_status_value = $random(seed);
    i_session_fetch_request = f;
    i_packet_start = 1;
    step;
    i_packet_start = 0;
    for (n = 0; n < 300 && !(o_context_ready && !o_busy); n++) step;
    chk({n < 300, far.rd_log.size()}, {1'b1, exp_rd.size()});
    foreach (exp_rd[j]) chk(far.rd_log[j], exp_rd[j]);
    chk(o_session_control_word, ec);
    chk(ctx_out, e_all);
    chk({o_mac_only, o_truncated_mac_result}, {ec[27], ec[25] & ec[16] & ec[14]});
    chk({o_keep_intermediate_hash, o_reload_keys}, ec[24:23]);
    chk(o_take_vector_from_session, ec[22]);
    chk({o_first_block_marker, o_outgoing_flow}, ec[21:20]);
    chk({o_primitive_select, o_cipher_direction}, ec[16:9]);
    chk({o_key_length_select, o_combined_operation_mode}, ec[8:4]);
    chk({o_cipher_chaining_mode, o_config_error}, {ec[3:0], ec[8:7] == 2'h3 || ec[29]});
    chk(o_counter_32bit, ec[12] && ec[3:0] == 4'hD);
    chk(o_status_merged, i_status_value | (ec[26] ? ec : 32'h0000_0000));
    km = ~256'h0 << (128 - 64 * ec[8:7]);
    if (ec[8:7] != 2'h3) chk(o_cipher_key_used, e_all[639:384] & km);
    chk({o_result_ready, o_busy}, 2'b10);
    for (i = 0; i < 8; i++) i_result_data[32 * i +: 32] = $random(seed);
    for (i = 0; i < 9; i++) far.mem[128 + i] = 32'h0000_0000;
    n = $random(seed);
    // The full field is driven so that the clamp at eight and the zero case are exercised too.
    i_result_words = n[3:0];
    m = i_result_words > 8 ? 8 : (i_result_words ? i_result_words : 1);
    if (ec[25] & ec[16] & ec[14]) m = 3;
    i_result_valid = 1;
    step;
    i_result_valid = 0;
    chk({o_result_ready, o_busy}, 2'b01);
    for (n = 0; n < 300 && o_result_done !== 1'b1; n++) step;
    chk(n < 300, 1);
    for (i = 0; i < 9; i++)
      chk(far.mem[128 + i], (i < m) * i_result_data[255 - 32 * i -: 32]);
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    #1 i_rst_b = 1;
    for (k = 0; k < 30; k++) begin
      c = $random(seed) & 32'h0FF1_FFFF;
      c[8:7] = k == 20 ? 2'h3 : 2'(k % 3);
      c[6:4] = k % 3 ? 3'(3 + 2 * (k % 3)) : 3'h0;
      c[3:0] = 4'(k % 15);
      if (k == 12) begin
        i_rst_b = 0;
        step;
        chk({o_busy, o_context_ready, o_session_control_word}, 0);
        i_rst_b = 1;
        {ec, e_all} = 0;
      end
      run_case(k != 5 && k != 6 && k != 13);
    end
    close_out;
  end
endmodule // session_context_decoder_tb
